/* design/cms_top.sv */
`timescale 1ns/1ns
// What this block does
// - Remote-inhibit setting: off permits remote operation, on refuses it.
// - Inhibit ignores remote acknowledge, setpoint-select input, remote select, remote start.
// - Enabled acknowledge input grants or withholds remote/automatic switching permission, in templates 32h and 35h only.
// - Manual-permit setting: automatic and manual, or automatic only.
// - Manual prohibited refuses forced-manual and manual start-up by input.
// - Start-up mode chosen by setting: automatic, remote or manual.
// - Remote start while inhibited: manual if forced-manual input on, else automatic.
// - Manual start while prohibited: remote if acknowledge and remote select, else auto.
// - Tracking on: leaving remote copies remote setpoint into local setpoint.
// - Tracking off: leaving remote restores local setpoint held at remote entry.
// - Tracking applies for either remote setpoint source: aux input or selection.
// - Remote entered during ramp/soak returns to ramp/soak setpoint regardless.
// - Passwords span 0000 to FFFF; first level blocks all setting changes.
// - Second level blocks all settings except the operation group.
// - Forty-four sixteen-bit mask words, each set bit hides a parameter.
// - Mask bits numbered 1 to 16 from the least significant end.
// - Mask words load their factory default values.
// - External level -25 to 125 percent drives output while its input is on.
// - Internal manipulated value follows external level for bumpless release.
// - Manual operation ignores external input and keeps the manual output.
// - External override is input code 103, assigned to input 4 at delivery.
module cms_top
	import cms_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] di_in,
	input wire logic [15:0] pid_mv,
	input wire logic [15:0] aux_analog_sp,
	input wire logic [15:0] ramp_sp,
	input wire logic ramp_active,
	output logic [1:0] mode_out,
	output logic [15:0] setpoint_out,
	output logic [15:0] mv_out,
	output logic [15:0] mv_follow
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic di_fn(input logic [31:0] f, input logic [3:0] d,
		input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 4; i++)
			if (d[i] && f[8*i +: 8] == code)
				hit = 1'b1;
		return hit;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	function automatic logic is_mask(input logic [11:0] a);
		return a[1:0] == 2'b00 && a >= OFS_MASK && a < OFS_MASK + 12'(4 * MASK_N);
	endfunction

	function automatic logic [5:0] mask_idx(input logic [11:0] a);
		logic [11:0] d;
		d = a - OFS_MASK;
		return d[7:2];
	endfunction

	function automatic logic signed [15:0] clamp_ext(input logic [15:0] v);
		logic signed [15:0] s;
		s = v;
		if (s < EXT_MIN)
			s = EXT_MIN;
		else if (s > EXT_MAX)
			s = EXT_MAX;
		return s;
	endfunction

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] ctrl;
	logic [7:0] control_template;
	logic [31:0] digital_input_function;
	logic [15:0] local_setpoint;
	logic [15:0] remote_setpoint;
	logic signed [15:0] external_output_level;
	logic [15:0] manual_mv;
	logic [15:0] pass_entry;
	logic [15:0] first_level_password;
	logic [15:0] second_level_password;
	logic [15:0] parameter_mask_word [0:MASK_N-1];
	logic aw_hold;
	logic w_hold;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [11:0] wa;
	logic [31:0] wd;
	logic wr_map;
	logic wr_oper;
	logic lock1;
	logic lock2;
	logic wr_ok;
	logic req_pulse;
	logic [1:0] req_mode;
	cms_mode_t mode;
	logic started;
	logic rsp_q;
	logic saved_ramp;
	logic [15:0] saved_lsp;

	// ----------------------------------------
	// Settings and input decode
	// ----------------------------------------
	logic remote_inhibit;
	logic manual_permit;
	logic remote_ok;
	logic rack_gate;
	logic rack_on;
	logic smv_on;
	logic svsel_on;
	logic exmv_on;
	logic rsp_act;
	logic [15:0] rsp_src;
	cms_mode_t start_mode;

	assign remote_inhibit = ctrl[B_RINH];
	assign manual_permit = ctrl[B_MPERM];
	assign rack_gate = ctrl[B_RACK] && !remote_inhibit
		&& (control_template == TPL_A || control_template == TPL_B);
	assign rack_on = di_fn(digital_input_function, di_in, FN_RACK);
	assign smv_on = di_fn(digital_input_function, di_in, FN_SMV);
	assign svsel_on = di_fn(digital_input_function, di_in, FN_SVSEL) && !remote_inhibit;
	assign exmv_on = di_fn(digital_input_function, di_in, FN_EXMV);
	// Remote needs no inhibit, remote select, and acknowledge when that gate is armed
	assign remote_ok = !remote_inhibit && ctrl[B_RSEL]
		&& (!rack_gate || rack_on);
	assign rsp_src = ctrl[B_AUXSRC] ? aux_analog_sp : remote_setpoint;
	assign rsp_act = (mode == MODE_REMOTE) || svsel_on;

	always_comb
	begin
		start_mode = MODE_AUTO;
		case (ctrl[B_SUP +: 2])
			2'd1:
			begin
				if (remote_ok)
					start_mode = MODE_REMOTE;
				else if (smv_on && manual_permit)
					start_mode = MODE_MANUAL;
			end
			2'd2:
			begin
				if (manual_permit)
					start_mode = MODE_MANUAL;
				else if (rack_on && remote_ok)
					start_mode = MODE_REMOTE;
			end
			default: start_mode = MODE_AUTO;
		endcase
	end

	// ----------------------------------------
	// Write decode and locks
	// ----------------------------------------
	assign do_write = aw_hold && w_hold && !s_axi_bvalid;
	assign wa = awaddr_q;
	assign wd = wdata_q;
	assign lock1 = first_level_password != 16'h0000 && pass_entry != first_level_password;
	assign lock2 = second_level_password != 16'h0000 && pass_entry != second_level_password;
	assign wr_oper = wa == OFS_REQ || wa == OFS_LSP || wa == OFS_EXT || wa == OFS_MANMV;

	always_comb
	begin
		case (wa)
			OFS_CTRL, OFS_REQ, OFS_TPL, OFS_DIFN, OFS_LSP, OFS_RSP, OFS_EXT, OFS_MANMV,
			OFS_PENTRY, OFS_PASS1, OFS_PASS2: wr_map = 1'b1;
			default: wr_map = is_mask(wa);
		endcase
	end

	// Password entry stays open so a locked unit can be unlocked
	assign wr_ok = wr_map && (wa == OFS_PENTRY
		|| (!lock1 && (!lock2 || wr_oper)));
	assign req_pulse = do_write && wr_ok && wa == OFS_REQ;
	assign req_mode = wd[1:0];

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
		end
		else
		begin
			s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_hold && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Setting registers
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ctrl <= CTRL_RESET;
			control_template <= TPL_RESET;
			digital_input_function <= DIFN_RESET;
			remote_setpoint <= 16'h0000;
			external_output_level <= 16'sh0000;
			manual_mv <= 16'h0000;
			pass_entry <= 16'h0000;
			first_level_password <= 16'h0000;
			second_level_password <= 16'h0000;
			for (int i = 0; i < MASK_N; i++)
				parameter_mask_word[i] <= MASK_RESET[i];
		end
		else if (do_write && wr_ok)
		begin
			case (wa)
				OFS_CTRL: ctrl <= 8'(merge({24'h0, ctrl}, wd, wstrb_q));
				OFS_TPL: control_template <= 8'(merge({24'h0, control_template}, wd, wstrb_q));
				OFS_DIFN: digital_input_function <= merge(digital_input_function, wd, wstrb_q);
				OFS_RSP: remote_setpoint <= 16'(merge({16'h0, remote_setpoint}, wd, wstrb_q));
				OFS_EXT: external_output_level <=
					clamp_ext(16'(merge({16'h0, external_output_level}, wd, wstrb_q)));
				OFS_MANMV: manual_mv <= 16'(merge({16'h0, manual_mv}, wd, wstrb_q));
				OFS_PENTRY: pass_entry <= 16'(merge({16'h0, pass_entry}, wd, wstrb_q));
				OFS_PASS1: first_level_password <=
					16'(merge({16'h0, first_level_password}, wd, wstrb_q));
				OFS_PASS2: second_level_password <=
					16'(merge({16'h0, second_level_password}, wd, wstrb_q));
				default:
				begin
					// Bytes with their write strobe set are replaced; bit n-1 holds mask bit n
					if (is_mask(wa))
						parameter_mask_word[mask_idx(wa)] <= 16'(merge({16'h0,
							parameter_mask_word[mask_idx(wa)]}, wd, wstrb_q));
				end
			endcase
		end
	end

	// ----------------------------------------
	// Operating mode
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			mode <= MODE_AUTO;
			started <= 1'b0;
		end
		else if (!started)
		begin
			started <= 1'b1;
			mode <= start_mode;
		end
		else if (smv_on && manual_permit)
			mode <= MODE_MANUAL;
		else if (req_pulse)
		begin
			case (req_mode)
				2'd1:
				begin
					if (manual_permit)
						mode <= MODE_MANUAL;
				end
				2'd3:
				begin
					if (remote_ok)
						mode <= MODE_REMOTE;
				end
				default: mode <= MODE_AUTO;
			endcase
		end
		else if (mode == MODE_REMOTE && !remote_ok)
			mode <= MODE_AUTO;
		else if (mode == MODE_MANUAL && !manual_permit)
			mode <= MODE_AUTO;
	end

	// ----------------------------------------
	// Local setpoint and tracking
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			local_setpoint <= 16'h0000;
			saved_lsp <= 16'h0000;
			saved_ramp <= 1'b0;
			rsp_q <= 1'b0;
		end
		else
		begin
			rsp_q <= rsp_act;
			if (rsp_act && !rsp_q)
			begin
				saved_lsp <= local_setpoint;
				saved_ramp <= ramp_active;
			end
			if (!rsp_act && rsp_q)
			begin
				if (saved_ramp)
					local_setpoint <= ramp_sp;
				else if (ctrl[B_TRK])
					local_setpoint <= rsp_src;
				else
					local_setpoint <= saved_lsp;
			end
			else if (do_write && wr_ok && wa == OFS_LSP)
				local_setpoint <= 16'(merge({16'h0, local_setpoint}, wd, wstrb_q));
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			mode_out <= MODE_AUTO;
			setpoint_out <= 16'h0000;
			mv_out <= 16'h0000;
			mv_follow <= 16'h0000;
		end
		else
		begin
			mode_out <= mode;
			if (rsp_act)
				setpoint_out <= rsp_src;
			else if (ramp_active)
				setpoint_out <= ramp_sp;
			else
				setpoint_out <= local_setpoint;
			if (mode == MODE_MANUAL)
			begin
				mv_out <= manual_mv;
				mv_follow <= manual_mv;
			end
			else if (exmv_on)
			begin
				mv_out <= external_output_level;
				mv_follow <= external_output_level;
			end
			else
			begin
				mv_out <= pid_mv;
				mv_follow <= pid_mv;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	logic [31:0] rd_val;
	logic rd_map;

	always_comb
	begin
		rd_map = 1'b1;
		rd_val = 32'h0000_0000;
		case (s_axi_araddr)
			OFS_CTRL: rd_val = {24'h0, ctrl};
			OFS_TPL: rd_val = {24'h0, control_template};
			OFS_DIFN: rd_val = digital_input_function;
			OFS_LSP: rd_val = {16'h0, local_setpoint};
			OFS_RSP: rd_val = {16'h0, remote_setpoint};
			OFS_EXT: rd_val = {16'h0, external_output_level};
			OFS_MANMV: rd_val = {16'h0, manual_mv};
			OFS_REQ, OFS_PENTRY, OFS_PASS1, OFS_PASS2: rd_val = 32'h0000_0000;
			OFS_STAT: rd_val = {24'h0, lock2, lock1, exmv_on, rsp_act, rack_on, started, mode};
			default:
			begin
				if (is_mask(s_axi_araddr))
					rd_val = {16'h0, parameter_mask_word[mask_idx(s_axi_araddr)]};
				else
					rd_map = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OK;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_map ? RESP_OK : RESP_ERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end
endmodule

/* include/cms_pkg.sv */
package cms_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_REQ = 12'h004;
	localparam logic [11:0] OFS_TPL = 12'h008;
	localparam logic [11:0] OFS_DIFN = 12'h00C;
	localparam logic [11:0] OFS_LSP = 12'h010;
	localparam logic [11:0] OFS_RSP = 12'h014;
	localparam logic [11:0] OFS_EXT = 12'h018;
	localparam logic [11:0] OFS_MANMV = 12'h01C;
	localparam logic [11:0] OFS_PENTRY = 12'h020;
	localparam logic [11:0] OFS_PASS1 = 12'h024;
	localparam logic [11:0] OFS_PASS2 = 12'h028;
	localparam logic [11:0] OFS_STAT = 12'h02C;
	localparam logic [11:0] OFS_MASK = 12'h100;
	localparam int MASK_N = 44;
	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int B_RINH = 0;
	localparam int B_RACK = 1;
	localparam int B_MPERM = 2;
	localparam int B_TRK = 3;
	localparam int B_SUP = 4;
	localparam int B_RSEL = 6;
	localparam int B_AUXSRC = 7;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h04;
	localparam logic [7:0] TPL_RESET = 8'h32;
	localparam logic [7:0] TPL_A = 8'h32;
	localparam logic [7:0] TPL_B = 8'h35;
	localparam logic [7:0] FN_RACK = 8'h3C;
	localparam logic [7:0] FN_EXMV = 8'h67;
	localparam logic [7:0] FN_SMV = 8'h14;
	localparam logic [7:0] FN_SVSEL = 8'h15;
	localparam logic [31:0] DIFN_RESET = 32'h6700_0000;
	localparam logic signed [15:0] EXT_MIN = -16'sd250;
	localparam logic signed [15:0] EXT_MAX = 16'sd1250;
	localparam logic [15:0] MASK_RESET [0:MASK_N-1] = '{
		16'h8000, 16'h002E, 16'h0000, 16'h4622, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0002,
		16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0000,
		16'h003E, 16'h0E24, 16'h000E, 16'h0002, 16'h0038, 16'h0038, 16'h01FF, 16'h001A,
		16'h01DF, 16'h80FC, 16'h0018, 16'h0EEE, 16'h0E0E, 16'h0007, 16'h00EE, 16'h0404,
		16'h1D00, 16'h0000, 16'hFF00, 16'h0003, 16'h0C31, 16'h0314, 16'h0010, 16'h0076,
		16'h00FC, 16'h01FF, 16'h01FF, 16'h01FF};
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	typedef enum logic [1:0] {
		MODE_AUTO = 2'b00,
		MODE_MANUAL = 2'b01,
		MODE_REMOTE = 2'b11
	} cms_mode_t;
endpackage

/* sim/cms_chk.sv */
`timescale 1ns/1ns
module cms_chk
	import cms_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] di_in,
	input wire logic [15:0] pid_mv,
	input wire logic [1:0] mode_out,
	input wire logic [15:0] mv_out,
	input wire logic [15:0] mv_follow
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	chk_b_after_wr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped");
	chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
	chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h1B0
		|=> s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0) else $error("unmapped read ok");
	// ----------------------------------------
	// Mode and output
	// ----------------------------------------
	chk_mode_code: assert property (mode_out != 2'b10)
		else $error("illegal mode code");
	chk_mv_follow: assert property ($stable(mv_out) [*3] |-> mv_follow == mv_out)
		else $error("internal value not following");
	chk_pid_pass: assert property ((di_in == 4'h0 && mode_out == MODE_AUTO
		&& $stable(pid_mv)) [*4] |-> mv_out == pid_mv) else $error("pid result not passed");
	cover property (mode_out == MODE_REMOTE);
	cover property (mode_out == MODE_MANUAL && di_in[3]);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_ERR);
endmodule
bind cms_top cms_chk u_chk (.*);

/* sim/cms_panel.sv */
`timescale 1ns/1ns
module cms_panel (
	input wire logic clk_sys,
	input wire logic [3:0] want_di,
	input wire logic slow,
	output logic [3:0] di_in = 4'h0
);
	logic [1:0] dly = 2'h0;
	// ----------------------------------------
	// Contacts settle at once or after a relay delay
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (want_di == di_in)
			dly <= 2'h0;
		else if (!slow || dly == 2'h3)
			di_in <= want_di;
		else
			dly <= dly + 2'h1;
	end
endmodule

/* sim/cms_top_bench.sv */
`timescale 1ns/1ns
module cms_top_bench
	import cms_pkg::*;
;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, mode_out;
	logic [31:0] s_axi_rdata;
	logic [3:0] di_in;
	logic [3:0] want_di = 4'h0;
	logic slow = 1'b0;
	logic ramp_active = 1'b0;
	logic [15:0] pid_mv = 16'h0000;
	logic [15:0] aux_analog_sp = 16'h0000;
	logic [15:0] ramp_sp = 16'h0000;
	logic [15:0] setpoint_out, mv_out, mv_follow, r1, r2;
	logic [33:0] exp_r [$];
	logic [1:0] exp_b [$];
	int err_total = 0;
	int samples_checked = 0;

	cms_top u_cms_top (.*);
	cms_panel u_cms_panel (.*);

	initial forever #20 clk_sys = ~clk_sys;
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", w, e, s);
			err_total++;
		end
	endtask

	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tick(inout int n);
		@(posedge clk_sys);
		n++;
		if (n > 60)
		begin
			$display("mismatch bus wait expected answer seen none");
			err_total++;
			report_and_stop();
		end
	endtask

	always @(posedge clk_sys)
	begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", exp_b.pop_front(), s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready)
		begin
			chk("rdata", exp_r[0][31:0], s_axi_rdata);
			chk("rresp", exp_r[0][33:32], s_axi_rresp);
			void'(exp_r.pop_front());
		end
	end

	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n = 0;
		exp_b.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n == 0 || !(s_axi_bvalid && s_axi_bready))
		begin
			tick(n);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n = 0;
		exp_r.push_back({er, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n == 0 || !(s_axi_rvalid && s_axi_rready))
		begin
			tick(n);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	function automatic logic [15:0] cur(input int k);
		case (k)
			0: return {14'h0000, mode_out};
			1: return setpoint_out;
			2: return mv_out;
			default: return mv_follow;
		endcase
	endfunction

	task automatic wv(input int k, input logic [15:0] e);
		for (int n = 0; n < 30 && cur(k) !== e; n++)
			@(posedge clk_sys);
		chk($sformatf("out%0d", k), {16'h0000, e}, {16'h0000, cur(k)});
	endtask

	task automatic hold(input int k, input logic [15:0] e);
		repeat (8) @(posedge clk_sys);
		chk($sformatf("out%0d", k), {16'h0000, e}, {16'h0000, cur(k)});
	endtask

	task automatic rq(input logic [1:0] m);
		axw(OFS_REQ, {30'h0, m}, RESP_OK);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(61));
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < MASK_N; i++)
			axr(OFS_MASK + 12'(4 * i), {16'h0000, MASK_RESET[i]}, RESP_OK);
		axr(OFS_CTRL, 32'h04, RESP_OK);
		axr(OFS_TPL, 32'h32, RESP_OK);
		axr(OFS_DIFN, 32'h6700_0000, RESP_OK);
		wv(0, MODE_AUTO);
		$display("test reset values done");
		r1 = 16'($urandom);
		axw(OFS_MASK + 12'h00C, 32'h1000, RESP_OK);
		axw(OFS_MASK + 12'h00C, 32'h1004, RESP_OK);
		axr(OFS_MASK + 12'h00C, 32'h1004, RESP_OK);
		axw(OFS_MASK + 12'h0AC, {16'h0000, r1}, RESP_OK);
		axr(OFS_MASK + 12'h0AC, {16'h0000, r1}, RESP_OK);
		axr(12'h1B0, 32'h0, RESP_ERR);
		axw(12'h1B0, 32'h1, RESP_ERR);
		axr(12'h102, 32'h0, RESP_ERR);
		$display("test masks done");
		rq(2'b01);
		wv(0, MODE_MANUAL);
		axw(OFS_MANMV, 32'h12C, RESP_OK);
		want_di <= 4'h8;
		wv(2, 16'h012C);
		hold(2, 16'h012C);
		want_di <= 4'h0;
		axw(OFS_CTRL, 32'h00, RESP_OK);
		wv(0, MODE_AUTO);
		rq(2'b01);
		hold(0, MODE_AUTO);
		axw(OFS_DIFN, 32'h6700_0014, RESP_OK);
		want_di <= 4'h1;
		hold(0, MODE_AUTO);
		axw(OFS_CTRL, 32'h04, RESP_OK);
		wv(0, MODE_MANUAL);
		want_di <= 4'h0;
		rq(2'b10);
		wv(0, MODE_AUTO);
		$display("test manual done");
		r2 = 16'($urandom);
		pid_mv <= r2;
		axw(OFS_EXT, 32'h1F4, RESP_OK);
		slow <= 1'b1;
		want_di <= 4'h8;
		wv(2, 16'h01F4);
		wv(3, 16'h01F4);
		want_di <= 4'h0;
		wv(2, r2);
		axw(OFS_EXT, 32'hFFFF_FE70, RESP_OK);
		want_di <= 4'h8;
		wv(2, 16'hFF06);
		want_di <= 4'h0;
		axw(OFS_EXT, 32'h7D0, RESP_OK);
		axr(OFS_EXT, 32'h4E2, RESP_OK);
		$display("test override done");
		axw(OFS_CTRL, 32'h44, RESP_OK);
		axw(OFS_LSP, 32'h7D0, RESP_OK);
		axw(OFS_RSP, {16'h0000, r1}, RESP_OK);
		rq(2'b11);
		wv(0, MODE_REMOTE);
		wv(1, r1);
		rq(2'b00);
		wv(1, 16'h07D0);
		axw(OFS_CTRL, 32'h4C, RESP_OK);
		rq(2'b11);
		rq(2'b00);
		hold(1, r1);
		aux_analog_sp <= r2;
		axw(OFS_CTRL, 32'hCC, RESP_OK);
		rq(2'b11);
		wv(1, r2);
		rq(2'b00);
		hold(1, r2);
		ramp_active <= 1'b1;
		ramp_sp <= ~r2;
		rq(2'b11);
		rq(2'b00);
		ramp_active <= 1'b0;
		hold(1, ~r2);
		axw(OFS_CTRL, 32'h45, RESP_OK);
		rq(2'b11);
		hold(0, MODE_AUTO);
		axw(OFS_CTRL, 32'h44, RESP_OK);
		rq(2'b11);
		wv(0, MODE_REMOTE);
		axw(OFS_CTRL, 32'h45, RESP_OK);
		wv(0, MODE_AUTO);
		$display("test remote done");
		axw(OFS_DIFN, 32'h6700_3C00, RESP_OK);
		axw(OFS_CTRL, 32'h46, RESP_OK);
		rq(2'b11);
		hold(0, MODE_AUTO);
		want_di <= 4'h2;
		hold(0, MODE_AUTO);
		rq(2'b11);
		wv(0, MODE_REMOTE);
		want_di <= 4'h0;
		wv(0, MODE_AUTO);
		axw(OFS_TPL, 32'h35, RESP_OK);
		rq(2'b11);
		hold(0, MODE_AUTO);
		axw(OFS_TPL, 32'h33, RESP_OK);
		rq(2'b11);
		wv(0, MODE_REMOTE);
		rq(2'b00);
		want_di <= 4'h2;
		axw(OFS_CTRL, 32'h47, RESP_OK);
		rq(2'b11);
		hold(0, MODE_AUTO);
		$display("test acknowledge done");
		r1 = 16'($urandom) | 16'h0001;
		axw(OFS_PASS1, {16'h0000, r1}, RESP_OK);
		axw(OFS_CTRL, 32'h04, RESP_ERR);
		axr(OFS_CTRL, 32'h47, RESP_OK);
		axw(OFS_PENTRY, {16'h0000, r1}, RESP_OK);
		axw(OFS_CTRL, 32'h04, RESP_OK);
		axw(OFS_PASS1, 32'h0, RESP_OK);
		axw(OFS_PASS2, 32'hFFFF, RESP_OK);
		axw(OFS_PENTRY, 32'h0, RESP_OK);
		axw(OFS_CTRL, 32'h44, RESP_ERR);
		axw(OFS_LSP, 32'h64, RESP_OK);
		wv(1, 16'h0064);
		axr(OFS_PASS2, 32'h0, RESP_OK);
		axw(OFS_PENTRY, 32'hFFFF, RESP_OK);
		axw(OFS_CTRL, 32'h44, RESP_OK);
		$display("test passwords done");
		report_and_stop();
	end
endmodule
